// File: pin_port_pkg.sv
// constants shared by the pin drive mode control block
package pin_port_pkg;

	// ------------------------------------------------------------
	// port shape
	// ------------------------------------------------------------
	localparam int NUM_PINS = 8;
	localparam int MODE_W = 3;
	localparam logic [7:0] USB_PINS_DEFAULT = 8'hc0;
	localparam logic [7:0] SPECIAL_PINS_DEFAULT = 8'h00;

	// ------------------------------------------------------------
	// register byte offsets, and the pin form page number matched against address bits 7:5
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_OUTPUT_DATA = 8'h00;
	localparam logic [7:0] OFF_PIN_STATE = 8'h04;
	localparam logic [7:0] OFF_DRIVE_MODE0 = 8'h08;
	localparam logic [7:0] OFF_DRIVE_MODE1 = 8'h0c;
	localparam logic [7:0] OFF_DRIVE_MODE2 = 8'h10;
	localparam logic [7:0] OFF_BYPASS = 8'h14;
	localparam logic [7:0] OFF_REGULATED = 8'h18;
	localparam logic [7:0] OFF_USB_MODE = 8'h1c;
	localparam logic [7:0] OFF_INT_RISE = 8'h20;
	localparam logic [7:0] OFF_INT_FALL = 8'h24;
	localparam logic [7:0] OFF_INT_STATUS = 8'h28;
	localparam logic [7:0] OFF_PORT_MODE_ALL = 8'h30;
	localparam logic [2:0] OFF_PIN_FORM_PAGE = 3'h2;

	// ------------------------------------------------------------
	// pin form field positions
	// ------------------------------------------------------------
	localparam int PF_DATA = 0;
	localparam int PF_MODE_LO = 1;
	localparam int PF_BYPASS = 4;
	localparam int PF_RISE = 5;
	localparam int PF_FALL = 6;
	localparam int PF_STATE = 7;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [23:0] DRIVE_MODE_RESET = 24'h000000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ------------------------------------------------------------
	// drive mode codes
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] MODE_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] MODE_RES_UP = 3'h2;
	localparam logic [2:0] MODE_RES_DOWN = 3'h3;
	localparam logic [2:0] MODE_OD_LOW = 3'h4;
	localparam logic [2:0] MODE_OD_HIGH = 3'h5;
	localparam logic [2:0] MODE_STRONG = 3'h6;
	localparam logic [2:0] MODE_RES_BOTH = 3'h7;

endpackage : pin_port_pkg

// File: port_ctrl_if.sv
// signals between the control top, the drive decoder and the edge monitor
`timescale 1ns/1ps
`default_nettype none
interface port_ctrl_if;
	logic [7:0][2:0] drive_mode_bits;
	logic [7:0] drive_data;
	logic [7:0] regulated;
	logic usb_mode;
	logic [7:0] oe;
	logic [7:0] dout;
	logic [7:0] pull_up;
	logic [7:0] pull_down;
	logic [7:0] inbuf_en;
	logic [7:0] pad_raw;
	logic [7:0] rise_en;
	logic [7:0] fall_en;
	logic [7:0] status_clr;
	logic [7:0] level;
	logic [7:0] status;
	modport ctrl (output drive_mode_bits, drive_data, regulated, usb_mode, pad_raw, rise_en,
		fall_en, status_clr, input oe, dout, pull_up, pull_down, inbuf_en, level, status);
	modport drv (input drive_mode_bits, drive_data, regulated, usb_mode,
		output oe, dout, pull_up, pull_down, inbuf_en);
	modport evt (input pad_raw, rise_en, fall_en, status_clr, output level, status);
endinterface : port_ctrl_if
`default_nettype wire

// File: drive_mode_decoder.sv
// per-pin drive mode decode into pad driver controls
`timescale 1ns/1ps
`default_nettype none
module drive_mode_decoder
	import pin_port_pkg::*;
#(
	parameter logic [7:0] USB_PINS = USB_PINS_DEFAULT
) (
	port_ctrl_if.drv bus
);

	// ------------------------------------------------------------
	// decode {oe, dout, pull_up, pull_down, inbuf}
	// ------------------------------------------------------------
	function automatic logic [4:0] decode_mode(input logic [2:0] m, input logic d,
		input logic reg_out);
		logic [4:0] r;
		r = 5'h01;
		unique case (m)
			MODE_HIZ_ANALOG: r = 5'h00;
			MODE_HIZ_DIGITAL: r = 5'h01;
			MODE_RES_UP: r = d ? 5'h05 : 5'h11;
			MODE_RES_DOWN: r = d ? 5'h19 : 5'h03;
			MODE_OD_LOW: r = d ? 5'h01 : 5'h11;
			MODE_OD_HIGH: r = d ? 5'h19 : 5'h01;
			MODE_STRONG: r = {1'b1, d, 3'h1};
			MODE_RES_BOTH: r = d ? 5'h05 : 5'h03;
		endcase
		if (reg_out) begin
			r[2:1] = 2'h0;
		end
		return r;
	endfunction : decode_mode

	// ------------------------------------------------------------
	// pin loop
	// ------------------------------------------------------------
	always_comb begin
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (USB_PINS[i]) begin
				if (bus.usb_mode) begin
					c = 5'h01;
				end else if (bus.drive_mode_bits[i][0]) begin
					c = {1'b1, bus.drive_data[i], 3'h1};
				end else if (bus.drive_data[i]) begin
					c = {2'h0, bus.drive_mode_bits[i][1], 1'b0, 1'b1};
				end else begin
					c = 5'h11;
				end
			end else begin
				c = decode_mode(bus.drive_mode_bits[i], bus.drive_data[i], bus.regulated[i]);
			end
			bus.oe[i] = c[4];
			bus.dout[i] = c[3];
			bus.pull_up[i] = c[2];
			bus.pull_down[i] = c[1];
			bus.inbuf_en[i] = c[0];
		end
	end

endmodule : drive_mode_decoder
`default_nettype wire

// File: pin_edge_monitor.sv
// pin input synchroniser, edge detect and sticky interrupt status
`timescale 1ns/1ps
`default_nettype none
module pin_edge_monitor
	import pin_port_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	port_ctrl_if.evt bus
);

	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic [7:0] status;
	} edge_state_type;

	edge_state_type st_reg;
	edge_state_type st_next;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] events;
		events = '0;
		st_next = st_reg;
		st_next.sync1 = bus.pad_raw;
		st_next.sync2 = st_reg.sync1;
		st_next.prev = st_reg.sync2;
		events = (bus.rise_en & st_reg.sync2 & ~st_reg.prev) |
			(bus.fall_en & ~st_reg.sync2 & st_reg.prev);
		st_next.status = (st_reg.status & ~bus.status_clr) | events;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.level = st_reg.sync2;
	assign bus.status = st_reg.status;

endmodule : pin_edge_monitor
`default_nettype wire

// File: pin_drive_mode_control.sv
// pin drive mode control for one eight-pin port with an apb register slave
//
// Behaviour
// - each general or special pin has a 3-bit mode; 000 and 001 are high impedance
// - drive follows output data, or digital system signal when bypass is set
// - 010 resistive high/strong low; 011 strong high/resistive low
// - 100 open drain low: high-z for 1, strong low for 0
// - 101 open drain high: strong high for 1, high-z for 0
// - 110 strong both ways; 111 resistive both ways
// - regulated special pins offer no resistive pulls
// - usb-capable pin drive enable is bit 7/6 of mode plane 0
// - usb-capable pin pull-up enable is bit 7/6 of mode plane 1
// - usb pins: 00 open drain low, drive 1 strong, pull only resistive high
// - usb mode makes usb pin drive and pull bits ineffective
// - port-wide configuration writes leave usb pin mode bits alone
// - registers reachable per port and per pin, same bits underneath
// - pin state read path separate from stored output data
// - each pin interrupts on rising, falling or both edges
// - the port has its own interrupt request line
// - no level interrupts; synced levels go out to the digital system
// - reset drive configuration is user programmable, applied at reset
// - after reset driver and input buffer are off; usb pins 7/6 here come out of reset driving strong low with input buffer on
// - each enabled edge sets the pin status bit and requests an interrupt
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pin_drive_mode_control
	import pin_port_pkg::*;
#(
	parameter logic [7:0] USB_PINS = USB_PINS_DEFAULT,
	parameter logic [7:0] SPECIAL_PINS = SPECIAL_PINS_DEFAULT,
	parameter logic [23:0] RESET_DRIVE_MODE = DRIVE_MODE_RESET
) (
	// clock and reset
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// pads
	input wire logic [7:0] PAD_IN,
	output logic [7:0] PAD_OUT,
	output logic [7:0] PAD_OE_OUT,
	output logic [7:0] PAD_PULL_UP_OUT,
	output logic [7:0] PAD_PULL_DOWN_OUT,
	output logic [7:0] PAD_INBUF_EN_OUT,
	// digital system
	input wire logic [7:0] DSI_DATA_IN,
	output logic [7:0] DSI_PIN_LEVEL_OUT,
	output logic USB_MODE_OUT,
	output logic PORT_IRQ_OUT
);

	typedef struct packed {
		logic [7:0] output_data_reg;
		logic [7:0] dm0;
		logic [7:0] dm1;
		logic [7:0] dm2;
		logic [7:0] output_bypass_select;
		logic [7:0] regulated;
		logic usb_mode;
		logic [7:0] rise_en;
		logic [7:0] fall_en;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] pad_out;
		logic [7:0] pad_oe;
		logic [7:0] pad_pu;
		logic [7:0] pad_pd;
		logic [7:0] pad_inen;
		logic [7:0] dsi_level;
		logic irq;
		logic usb_out;
	} ctrl_state_type;

	// general pins take port-wide mode writes, usb pins do not
	localparam logic [7:0] GENERAL_PINS = ~USB_PINS;

	// ------------------------------------------------------------
	// reset image
	// ------------------------------------------------------------
	function automatic logic [7:0] plane(input logic [23:0] modes, input int bit_sel);
		logic [7:0] p;
		p = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			p[i] = modes[i * MODE_W + bit_sel];
		end
		return p;
	endfunction : plane

	localparam ctrl_state_type RESET_STATE = '{
		output_data_reg: BYTE_RESET,
		dm0: plane(RESET_DRIVE_MODE, 0),
		dm1: plane(RESET_DRIVE_MODE, 1),
		dm2: plane(RESET_DRIVE_MODE, 2) & GENERAL_PINS,
		output_bypass_select: BYTE_RESET,
		regulated: BYTE_RESET,
		usb_mode: 1'b0,
		rise_en: BYTE_RESET,
		fall_en: BYTE_RESET,
		prdata: 32'h00000000,
		pready: 1'b0,
		pslverr: 1'b0,
		pad_out: BYTE_RESET,
		pad_oe: BYTE_RESET,
		pad_pu: BYTE_RESET,
		pad_pd: BYTE_RESET,
		pad_inen: BYTE_RESET,
		dsi_level: BYTE_RESET,
		irq: 1'b0,
		usb_out: 1'b0
	};

	ctrl_state_type st_reg;
	ctrl_state_type st_next;

	port_ctrl_if pc ();

	// ------------------------------------------------------------
	// sub blocks
	// ------------------------------------------------------------
	drive_mode_decoder #(
		.USB_PINS(USB_PINS)
	) u_decoder (
		.bus(pc.drv)
	);

	pin_edge_monitor u_edges (
		.clk(REF_CLK_IN),
		.arst_n(ARST_N_IN),
		.bus(pc.evt)
	);

	// ------------------------------------------------------------
	// sub block wiring
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pc.drive_mode_bits[i] = {st_reg.dm2[i], st_reg.dm1[i], st_reg.dm0[i]};
		end
	end

	assign pc.drive_data = (st_reg.output_bypass_select & DSI_DATA_IN) |
		(~st_reg.output_bypass_select & st_reg.output_data_reg);
	assign pc.regulated = st_reg.regulated & SPECIAL_PINS;
	assign pc.usb_mode = st_reg.usb_mode;
	assign pc.pad_raw = PAD_IN;
	assign pc.rise_en = st_reg.rise_en;
	assign pc.fall_en = st_reg.fall_en;

	// ------------------------------------------------------------
	// apb decode and register update
	// ------------------------------------------------------------
	logic access;
	logic hit;
	logic pin_form;
	logic [2:0] pin_idx;
	logic [31:0] rd;
	logic [7:0] wd;
	logic [7:0] clr;

	always_comb begin
		access = PSEL_IN & PENABLE_IN & st_reg.pready;
		pin_form = (PADDR_IN[7:5] == OFF_PIN_FORM_PAGE) && (PADDR_IN[1:0] == 2'h0);
		pin_idx = PADDR_IN[4:2];
		wd = PWDATA_IN[7:0];
		hit = 1'b1;
		rd = 32'h00000000;
		if (pin_form) begin
			rd[PF_DATA] = st_reg.output_data_reg[pin_idx];
			rd[PF_MODE_LO] = st_reg.dm0[pin_idx];
			rd[PF_MODE_LO + 1] = st_reg.dm1[pin_idx];
			rd[PF_MODE_LO + 2] = st_reg.dm2[pin_idx];
			rd[PF_BYPASS] = st_reg.output_bypass_select[pin_idx];
			rd[PF_RISE] = st_reg.rise_en[pin_idx];
			rd[PF_FALL] = st_reg.fall_en[pin_idx];
			rd[PF_STATE] = pc.level[pin_idx];
		end else begin
			unique case (PADDR_IN)
				OFF_OUTPUT_DATA: rd[7:0] = st_reg.output_data_reg;
				OFF_PIN_STATE: rd[7:0] = pc.level;
				OFF_DRIVE_MODE0: rd[7:0] = st_reg.dm0;
				OFF_DRIVE_MODE1: rd[7:0] = st_reg.dm1;
				OFF_DRIVE_MODE2: rd[7:0] = st_reg.dm2;
				OFF_BYPASS: rd[7:0] = st_reg.output_bypass_select;
				OFF_REGULATED: rd[7:0] = st_reg.regulated;
				OFF_USB_MODE: rd[0] = st_reg.usb_mode;
				OFF_INT_RISE: rd[7:0] = st_reg.rise_en;
				OFF_INT_FALL: rd[7:0] = st_reg.fall_en;
				OFF_INT_STATUS: rd[7:0] = pc.status;
				OFF_PORT_MODE_ALL: rd = 32'h00000000;
				default: hit = 1'b0;
			endcase
		end

		st_next = st_reg;
		clr = 8'h00;
		st_next.pready = PSEL_IN & PENABLE_IN & ~st_reg.pready;
		st_next.pslverr = st_next.pready & ~hit;
		st_next.prdata = (st_next.pready && !PWRITE_IN && hit) ? rd : 32'h00000000;

		if (access && PWRITE_IN && hit) begin
			if (pin_form) begin
				st_next.output_data_reg[pin_idx] = wd[PF_DATA];
				st_next.dm0[pin_idx] = wd[PF_MODE_LO];
				st_next.dm1[pin_idx] = wd[PF_MODE_LO + 1];
				st_next.dm2[pin_idx] = wd[PF_MODE_LO + 2] & GENERAL_PINS[pin_idx];
				st_next.output_bypass_select[pin_idx] = wd[PF_BYPASS];
				st_next.rise_en[pin_idx] = wd[PF_RISE];
				st_next.fall_en[pin_idx] = wd[PF_FALL];
			end else begin
				unique case (PADDR_IN)
					OFF_OUTPUT_DATA: st_next.output_data_reg = wd;
					OFF_DRIVE_MODE0: st_next.dm0 = wd;
					OFF_DRIVE_MODE1: st_next.dm1 = wd;
					OFF_DRIVE_MODE2: st_next.dm2 = wd & GENERAL_PINS;
					OFF_BYPASS: st_next.output_bypass_select = wd;
					OFF_REGULATED: st_next.regulated = wd & SPECIAL_PINS;
					OFF_USB_MODE: st_next.usb_mode = wd[0];
					OFF_INT_RISE: st_next.rise_en = wd;
					OFF_INT_FALL: st_next.fall_en = wd;
					OFF_INT_STATUS: clr = wd;
					OFF_PORT_MODE_ALL: begin
						st_next.dm0 = (st_reg.dm0 & USB_PINS) | ({8{wd[0]}} & GENERAL_PINS);
						st_next.dm1 = (st_reg.dm1 & USB_PINS) | ({8{wd[1]}} & GENERAL_PINS);
						st_next.dm2 = {8{wd[2]}} & GENERAL_PINS;
					end
					default: clr = 8'h00;
				endcase
			end
		end

		// registered pad and system outputs
		st_next.pad_out = pc.dout;
		st_next.pad_oe = pc.oe;
		st_next.pad_pu = pc.pull_up;
		st_next.pad_pd = pc.pull_down;
		st_next.pad_inen = pc.inbuf_en;
		st_next.dsi_level = pc.level;
		st_next.irq = |pc.status;
		// usb mode flag leaves in step with the pad controls it switches
		st_next.usb_out = st_reg.usb_mode;
	end

	assign pc.status_clr = clr;

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			st_reg <= RESET_STATE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign PRDATA_OUT = st_reg.prdata;
	assign PREADY_OUT = st_reg.pready;
	assign PSLVERR_OUT = st_reg.pslverr;
	assign PAD_OUT = st_reg.pad_out;
	assign PAD_OE_OUT = st_reg.pad_oe;
	assign PAD_PULL_UP_OUT = st_reg.pad_pu;
	assign PAD_PULL_DOWN_OUT = st_reg.pad_pd;
	assign PAD_INBUF_EN_OUT = st_reg.pad_inen;
	assign DSI_PIN_LEVEL_OUT = st_reg.dsi_level;
	assign USB_MODE_OUT = st_reg.usb_out;
	assign PORT_IRQ_OUT = st_reg.irq;

endmodule : pin_drive_mode_control
`default_nettype wire

// File: pad_load_model.sv
// external circuitry model resolving each port pad
`timescale 1ns/1ps
`default_nettype none
module pad_load_model (
	// clock
	input wire logic clk_in,
	// pad controls
	input wire logic [7:0] oe_in,
	input wire logic [7:0] dout_in,
	input wire logic [7:0] pu_in,
	input wire logic [7:0] pd_in,
	// outside source
	input wire logic [7:0] ext_en_in,
	input wire logic [7:0] ext_val_in,
	// resolved level
	output logic [7:0] level_out
);
	logic [7:0] float_reg = 8'h55;
	// an undriven pad wanders every cycle
	always @(posedge clk_in) begin
		float_reg <= ~float_reg;
	end
	// strong driver, then outside source, then pulls
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level_out[i] = oe_in[i] ? dout_in[i] : ext_en_in[i] ? ext_val_in[i] :
				pu_in[i] ? 1'b1 : pd_in[i] ? 1'b0 : float_reg[i];
		end
	end
endmodule : pad_load_model
`default_nettype wire

// File: pin_drive_mode_control_chk.sv
// assertions on the pin drive mode control ports
`timescale 1ns/1ps
`default_nettype none
module pin_drive_mode_control_chk
	import pin_port_pkg::*;
#(
	parameter logic [7:0] USB_PINS = USB_PINS_DEFAULT
) (
	// clock and reset
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	// apb
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	// pads and digital system
	input wire logic [7:0] PAD_IN,
	input wire logic [7:0] PAD_OE_OUT,
	input wire logic [7:0] PAD_PULL_UP_OUT,
	input wire logic [7:0] PAD_PULL_DOWN_OUT,
	input wire logic [7:0] DSI_PIN_LEVEL_OUT,
	input wire logic USB_MODE_OUT,
	input wire logic PORT_IRQ_OUT
);
	default clocking dck @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);
	logic [2:0] age_reg;
	logic [2:0] age_next;
	logic clr_wr;
	assign clr_wr = PSEL_IN && PWRITE_IN && (PADDR_IN == OFF_INT_STATUS);
	always_comb begin
		age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
	end
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			age_reg <= 3'h0;
		end else begin
			age_reg <= age_next;
		end
	end
	// ----
	// sequences and properties
	// ----
	sequence s_setup_access;
		PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN;
	endsequence
	sequence s_level_moved;
		$past(DSI_PIN_LEVEL_OUT) != $past(DSI_PIN_LEVEL_OUT, 2);
	endsequence
	property p_ready;
		s_setup_access |=> PREADY_OUT;
	endproperty
	property p_err_ready;
		PSLVERR_OUT |-> PREADY_OUT;
	endproperty
	property p_rdata_idle;
		!PREADY_OUT |-> PRDATA_OUT == 32'h0;
	endproperty
	property p_pull_excl;
		(PAD_PULL_UP_OUT & PAD_PULL_DOWN_OUT) == 8'h00;
	endproperty
	property p_oe_excl;
		(PAD_OE_OUT & (PAD_PULL_UP_OUT | PAD_PULL_DOWN_OUT)) == 8'h00;
	endproperty
	property p_usb_off;
		USB_MODE_OUT |-> ((PAD_OE_OUT | PAD_PULL_UP_OUT | PAD_PULL_DOWN_OUT) & USB_PINS) == 8'h00;
	endproperty
	property p_sync;
		(age_reg >= 3'h4) |-> DSI_PIN_LEVEL_OUT == $past(PAD_IN, 3);
	endproperty
	property p_irq_rise;
		$rose(PORT_IRQ_OUT) |-> s_level_moved;
	endproperty
	property p_irq_hold;
		PORT_IRQ_OUT && !clr_wr && !$past(clr_wr) |=> PORT_IRQ_OUT;
	endproperty
	a_ready: assert property (p_ready) else $error("ready late");
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
	a_oe_excl: assert property (p_oe_excl) else $error("driver and pull on");
	a_usb_off: assert property (p_usb_off) else $error("usb pin driven in usb mode");
	a_sync: assert property (p_sync) else $error("pin level not synced");
	a_irq_rise: assert property (p_irq_rise) else $error("request without edge");
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
endmodule : pin_drive_mode_control_chk
bind pin_drive_mode_control pin_drive_mode_control_chk #(.USB_PINS(USB_PINS)) u_chk (
	.REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.PAD_IN(PAD_IN), .PAD_OE_OUT(PAD_OE_OUT), .PAD_PULL_UP_OUT(PAD_PULL_UP_OUT),
	.PAD_PULL_DOWN_OUT(PAD_PULL_DOWN_OUT), .DSI_PIN_LEVEL_OUT(DSI_PIN_LEVEL_OUT),
	.USB_MODE_OUT(USB_MODE_OUT), .PORT_IRQ_OUT(PORT_IRQ_OUT)
);
`default_nettype wire

// File: pin_drive_mode_control_tb.sv
// testbench for the pin drive mode control block
`timescale 1ns/1ps
`default_nettype none
module pin_drive_mode_control_tb;
	import pin_port_pkg::*;
	logic clk, rst_n, psel, pen, pwr, usb_mode, irq, pready, pslverr;
	logic [7:0] paddr, pad_in, pad_out, pad_oe, pu, pd, inbuf, dsi, dsi_lvl, ext_en, ext_val;
	logic [31:0] pwdata, prdata;
	int failures = 0;
	int samples_checked = 0;
	pin_drive_mode_control #(.SPECIAL_PINS(8'h01), .RESET_DRIVE_MODE(24'h000030)) dut (
		.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PAD_IN(pad_in), .PAD_OUT(pad_out),
		.PAD_OE_OUT(pad_oe), .PAD_PULL_UP_OUT(pu), .PAD_PULL_DOWN_OUT(pd),
		.PAD_INBUF_EN_OUT(inbuf), .DSI_DATA_IN(dsi), .DSI_PIN_LEVEL_OUT(dsi_lvl),
		.USB_MODE_OUT(usb_mode), .PORT_IRQ_OUT(irq));
	pad_load_model u_load (.clk_in(clk), .oe_in(pad_oe), .dout_in(pad_out), .pu_in(pu),
		.pd_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_in));
	always #4 clk = ~clk;
	// ----
	// helpers
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		chk(r, {24'h0, exp});
	endtask : rd
	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle
	function automatic logic [31:0] gp(input logic [2:0] m, input logic d);
		case (m)
			MODE_RES_UP: gp = d ? 32'h2 : 32'h8;
			MODE_RES_DOWN: gp = d ? 32'hc : 32'h1;
			MODE_OD_LOW: gp = d ? 32'h0 : 32'h8;
			MODE_OD_HIGH: gp = d ? 32'hc : 32'h0;
			MODE_STRONG: gp = d ? 32'hc : 32'h8;
			MODE_RES_BOTH: gp = d ? 32'h2 : 32'h1;
			default: gp = 32'h0;
		endcase
	endfunction : gp
	function automatic logic [31:0] usb(input logic p, input logic dv, input logic d);
		usb = dv ? (d ? 32'hc : 32'h8) : p ? (d ? 32'h2 : 32'h8) : (d ? 32'h0 : 32'h8);
	endfunction : usb
	function automatic logic [31:0] pv(input int i);
		pv = {28'h0, pad_oe[i], pad_oe[i] & pad_out[i], pu[i], pd[i]};
	endfunction : pv
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	// ----
	// tests
	// ----
	initial begin
		#100000;
		failures++;
		close_out();
	end
	initial begin
		logic [2:0] m;
		logic dd;
		logic [31:0] r;
		logic e;
		clk = 1'b0;
		rst_n = 1'b0;
		{psel, pen, pwr, paddr, pwdata, dsi, ext_en, ext_val} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk({24'h0, pad_oe}, 32'hc2);
		chk({24'h0, inbuf & 8'h3d}, 32'h0);
		rd(OFF_DRIVE_MODE1, 8'h02);
		apb(1'b0, 8'h2c, 8'h00, r, e);
		chk({31'h0, e}, 32'h1);
		for (int k = 0; k < 16; k++) begin
			m = k[3:1];
			dd = k[0];
			wr(OFF_DRIVE_MODE0, {8{m[0]}});
			wr(OFF_DRIVE_MODE1, {8{m[1]}});
			wr(OFF_DRIVE_MODE2, {8{m[2]}});
			wr(OFF_OUTPUT_DATA, {8{dd}});
			settle();
			for (int i = 0; i < 6; i++) begin
				chk(pv(i), gp(m, dd));
			end
			chk({31'h0, inbuf[0]}, {31'h0, m != MODE_HIZ_ANALOG});
			chk(pv(6), usb(m[1], m[0], dd));
			chk(pv(7), usb(m[1], m[0], dd));
		end
		wr(8'h4c, 8'h0d);
		rd(OFF_DRIVE_MODE0, 8'hf7);
		settle();
		chk(pv(3), gp(MODE_STRONG, 1'b1));
		wr(OFF_PORT_MODE_ALL, 8'h00);
		rd(OFF_DRIVE_MODE0, 8'hc0);
		rd(OFF_DRIVE_MODE1, 8'hc0);
		wr(OFF_PORT_MODE_ALL, {5'h0, MODE_STRONG});
		wr(OFF_OUTPUT_DATA, 8'h00);
		dsi <= 8'h2a;
		wr(OFF_BYPASS, 8'h3f);
		settle();
		chk({24'h0, pad_out & pad_oe & 8'h3f}, 32'h2a);
		wr(OFF_BYPASS, 8'h00);
		settle();
		chk({24'h0, pad_out & pad_oe & 8'h3f}, 32'h0);
		wr(OFF_PORT_MODE_ALL, {5'h0, MODE_RES_BOTH});
		wr(OFF_OUTPUT_DATA, 8'hff);
		wr(OFF_REGULATED, 8'h01);
		settle();
		chk({30'h0, pu[1:0]}, 32'h2);
		wr(OFF_USB_MODE, 8'h01);
		settle();
		chk({29'h0, usb_mode, pad_oe[7:6]}, 32'h4);
		wr(OFF_USB_MODE, 8'h00);
		wr(OFF_PORT_MODE_ALL, {5'h0, MODE_HIZ_DIGITAL});
		wr(OFF_REGULATED, 8'h00);
		wr(OFF_OUTPUT_DATA, 8'h5a);
		ext_en <= 8'h3f;
		wr(OFF_INT_RISE, 8'h01);
		wr(OFF_INT_FALL, 8'h02);
		wr(OFF_INT_STATUS, 8'hff);
		ext_val <= 8'h03;
		settle();
		settle();
		rd(OFF_INT_STATUS, 8'h01);
		chk({31'h0, irq}, 32'h1);
		rd(OFF_PIN_STATE, 8'h43);
		chk({24'h0, dsi_lvl}, 32'h43);
		rd(OFF_OUTPUT_DATA, 8'h5a);
		wr(OFF_INT_STATUS, 8'h01);
		settle();
		chk({31'h0, irq}, 32'h0);
		ext_val <= 8'h00;
		settle();
		settle();
		rd(OFF_INT_STATUS, 8'h02);
		close_out();
	end
endmodule : pin_drive_mode_control_tb
`default_nettype wire
